// ===== hw/addr_map_defines.vh
// address map constants for the system address map decoder
`ifndef ADDR_MAP_DEFINES_VH
`define ADDR_MAP_DEFINES_VH

// ---------------------------------------------------------------
// region bounds
// ---------------------------------------------------------------
`define FLASH_BASE       32'h00000000
`define FLASH_LAST       32'h00007fff
`define SRAM_BASE        32'h20000000
`define SRAM_LAST        32'h20001fff
`define SRAM_ALIAS_BASE  32'h22000000
`define SRAM_ALIAS_LAST  32'h2203ffff
`define PERIPH_BASE      32'h40000000
`define PERIPH_LAST      32'h400fffff
`define PERIPH_ALIAS_BASE 32'h42000000
`define PERIPH_ALIAS_LAST 32'h43ffffff
`define PRIV_BASE        32'he0000000
`define PRIV_LAST        32'he00fffff
`define INSTR_TRACE_BASE 32'he0000000
`define WATCH_BASE       32'he0001000
`define BRKPT_BASE       32'he0002000
`define SYS_CTRL_BASE    32'he000e000
`define TRACE_PORT_BASE  32'he0040000
`define SLOT_LAST_OFS    32'h00000fff

// populated 4 KB peripheral slots, one bit per slot
`define PERIPH_SLOT_MASK 256'h60000000_00000000_00000000_00000000_00000000_00000000_11070110_000031f1

// ---------------------------------------------------------------
// region kinds by the top three address bits
// ---------------------------------------------------------------
`define RGN_CODE    3'h0
`define RGN_SRAM    3'h1
`define RGN_PERIPH  3'h2
`define RGN_XRAM_LO 3'h3
`define RGN_XRAM_HI 3'h4
`define RGN_XDEV_LO 3'h5
`define RGN_XDEV_HI 3'h6

// ---------------------------------------------------------------
// memory types
// ---------------------------------------------------------------
`define MT_NORMAL   2'h0
`define MT_DEVICE   2'h1
`define MT_STRONG   2'h2

// ---------------------------------------------------------------
// target select indices
// ---------------------------------------------------------------
`define TGT_COUNT   9
`define TGT_NONE    4'h0
`define TGT_FLASH   4'h1
`define TGT_SRAM    4'h2
`define TGT_PERIPH  4'h3
`define TGT_ITRACE  4'h4
`define TGT_WATCH   4'h5
`define TGT_BRKPT   4'h6
`define TGT_SYSCTL  4'h7
`define TGT_TPORT   4'h8

`endif

// ===== hw/system_address_map_decoder.v
// address decoder, region attributes, bit alias and barrier sequencing
`timescale 1ns/1ps
`default_nettype none
`include "addr_map_defines.vh"

module system_address_map_decoder (
    // clock, reset, enable
    input  wire        ref_clk_i,
    input  wire        nrst_i,
    input  wire        ce_i,
    // core request
    input  wire        req_valid_i,
    input  wire [31:0] req_addr_i,
    input  wire        req_write_i,
    input  wire        req_fetch_i,
    input  wire [31:0] req_wdata_i,
    output reg         req_ready_o,
    // core response
    output reg         resp_valid_o,
    output reg         resp_err_o,
    output reg         resp_xn_o,
    output reg  [31:0] resp_rdata_o,
    // barriers
    input  wire        data_order_barrier_i,
    input  wire        data_sync_barrier_i,
    input  wire        instr_sync_barrier_i,
    output reg         exec_stall_o,
    output reg         prefetch_flush_o,
    // region protection unit override
    input  wire        region_protection_unit_en_i,
    input  wire [1:0]  region_protection_unit_type_i,
    input  wire        region_protection_unit_xn_i,
    // downstream target
    output reg         tgt_valid_o,
    output reg         tgt_write_o,
    output reg  [31:0] tgt_addr_o,
    output reg  [31:0] tgt_wdata_o,
    output reg  [8:0]  tgt_sel_o,
    output reg  [1:0]  tgt_mem_type_o,
    output reg         tgt_execute_never_attr_o,
    output reg         tgt_posted_o,
    output reg  [7:0]  periph_slot_o,
    input  wire        tgt_done_i,
    input  wire [31:0] tgt_rdata_i
);

// ---------------------------------------------------------------
// states
// ---------------------------------------------------------------
localparam [1:0] S_IDLE   = 2'h0;
localparam [1:0] S_ACCESS = 2'h1;
localparam [1:0] S_RMW_RD = 2'h2;

reg  [1:0]  state_r;
reg  [1:0]  state_nxt;
reg         alias_r;
reg  [4:0]  bit_r;
reg         bitval_r;
reg         posted_r;
reg         dmb_pend_r;
reg         dsb_pend_r;
reg         isb_pend_r;

// ---------------------------------------------------------------
// decode of the presented address
// ---------------------------------------------------------------
reg         d_fault;
reg  [3:0]  d_sel;
reg  [1:0]  d_type;
reg         d_xn;
reg         d_alias;
reg  [31:0] d_paddr;
reg  [4:0]  d_bit;
reg  [31:0] ofs;
reg  [31:0] bb_addr;

wire [31:0] a = req_addr_i;

// a literal cannot be bit-selected, so the slot map lives in a vector
wire [255:0] slot_mask = `PERIPH_SLOT_MASK;

always @* begin
    d_fault = 1'b1;
    d_sel   = `TGT_NONE;
    d_alias = 1'b0;
    d_paddr = a;
    d_bit   = 5'h00;
    ofs     = 32'h00000000;
    bb_addr = 32'h00000000;
    // attributes follow the 512 MB region unless the override is enabled
    case (a[31:29])
        `RGN_CODE, `RGN_SRAM, `RGN_XRAM_LO, `RGN_XRAM_HI: begin
            d_type = `MT_NORMAL;
            d_xn   = 1'b0;
        end
        `RGN_PERIPH, `RGN_XDEV_LO, `RGN_XDEV_HI: begin
            d_type = `MT_DEVICE;
            d_xn   = 1'b1;
        end
        default: begin
            d_type = `MT_STRONG;
            d_xn   = 1'b1;
        end
    endcase
    // routing; anything not matched stays a fault
    if (a <= `FLASH_LAST) begin
        d_fault = 1'b0;
        d_sel   = `TGT_FLASH;
    end else if (a >= `SRAM_BASE && a <= `SRAM_LAST) begin
        d_fault = 1'b0;
        d_sel   = `TGT_SRAM;
    end else if (a >= `SRAM_ALIAS_BASE && a <= `SRAM_ALIAS_LAST && !req_fetch_i) begin
        ofs     = a - `SRAM_ALIAS_BASE;
        bb_addr = `SRAM_BASE + {12'h000, ofs[24:5]};
        d_fault = 1'b0;
        d_sel   = `TGT_SRAM;
        d_alias = 1'b1;
    end else if (a >= `PERIPH_BASE && a <= `PERIPH_LAST) begin
        d_fault = ~slot_mask[a[19:12]];
        d_sel   = d_fault ? `TGT_NONE : `TGT_PERIPH;
    end else if (a >= `PERIPH_ALIAS_BASE && a <= `PERIPH_ALIAS_LAST) begin
        ofs     = a - `PERIPH_ALIAS_BASE;
        bb_addr = `PERIPH_BASE + {12'h000, ofs[24:5]};
        d_fault = ~slot_mask[bb_addr[19:12]];
        d_sel   = d_fault ? `TGT_NONE : `TGT_PERIPH;
        d_alias = 1'b1;
    end else if (a >= `INSTR_TRACE_BASE && a <= `INSTR_TRACE_BASE + `SLOT_LAST_OFS) begin
        d_fault = 1'b0;
        d_sel   = `TGT_ITRACE;
    end else if (a >= `WATCH_BASE && a <= `WATCH_BASE + `SLOT_LAST_OFS) begin
        d_fault = 1'b0;
        d_sel   = `TGT_WATCH;
    end else if (a >= `BRKPT_BASE && a <= `BRKPT_BASE + `SLOT_LAST_OFS) begin
        d_fault = 1'b0;
        d_sel   = `TGT_BRKPT;
    end else if (a >= `SYS_CTRL_BASE && a <= `SYS_CTRL_BASE + `SLOT_LAST_OFS) begin
        d_fault = 1'b0;
        d_sel   = `TGT_SYSCTL;
    end else if (a >= `TRACE_PORT_BASE && a <= `TRACE_PORT_BASE + `SLOT_LAST_OFS) begin
        d_fault = 1'b0;
        d_sel   = `TGT_TPORT;
    end
    if (d_alias) begin
        // word access to the bit's word, bit index within that word
        d_paddr = {bb_addr[31:2], 2'b00};
        d_bit   = {bb_addr[1:0], ofs[4:2]};
    end
    if (region_protection_unit_en_i) begin
        d_type = region_protection_unit_type_i;
        d_xn   = region_protection_unit_xn_i;
    end
end

// ---------------------------------------------------------------
// target select
// ---------------------------------------------------------------
// one-hot select, exactly one bit set even for faults
wire [8:0] sel_onehot;
genvar g;
generate
    for (g = 0; g < `TGT_COUNT; g = g + 1) begin : g_sel
        localparam [3:0] SEL_IDX = g;
        assign sel_onehot[g] = (d_sel == SEL_IDX);
    end
endgenerate

// ---------------------------------------------------------------
// request sequencing
// ---------------------------------------------------------------
wire take     = req_valid_i & req_ready_o;
// fetches, speculative prefetch included, decode like reads except that the SRAM alias faults for them
wire fetch_xn = req_fetch_i & d_xn;

always @* begin
    state_nxt = state_r;
    case (state_r)
        S_IDLE: begin
            if (take && !fetch_xn && !d_fault) begin
                state_nxt = (d_alias && req_write_i) ? S_RMW_RD : S_ACCESS;
            end
        end
        S_ACCESS: begin
            if (tgt_done_i) begin
                state_nxt = S_IDLE;
            end
        end
        S_RMW_RD: begin
            if (tgt_done_i) begin
                state_nxt = S_ACCESS;
            end
        end
        default: begin
            state_nxt = S_IDLE;
        end
    endcase
end

// ---------------------------------------------------------------
// registers
// ---------------------------------------------------------------
always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        state_r                  <= S_IDLE;
        alias_r                  <= 1'b0;
        bit_r                    <= 5'h00;
        bitval_r                 <= 1'b0;
        posted_r                 <= 1'b0;
        dmb_pend_r               <= 1'b0;
        dsb_pend_r               <= 1'b0;
        isb_pend_r               <= 1'b0;
        req_ready_o              <= 1'b0;
        resp_valid_o             <= 1'b0;
        resp_err_o               <= 1'b0;
        resp_xn_o                <= 1'b0;
        resp_rdata_o             <= 32'h00000000;
        exec_stall_o             <= 1'b0;
        prefetch_flush_o         <= 1'b0;
        tgt_valid_o              <= 1'b0;
        tgt_write_o              <= 1'b0;
        tgt_addr_o               <= 32'h00000000;
        tgt_wdata_o              <= 32'h00000000;
        tgt_sel_o                <= 9'h001;
        tgt_mem_type_o           <= `MT_NORMAL;
        tgt_execute_never_attr_o <= 1'b0;
        tgt_posted_o             <= 1'b0;
        periph_slot_o            <= 8'h00;
    end else if (ce_i) begin
        state_r      <= state_nxt;
        resp_valid_o <= 1'b0;
        resp_err_o   <= 1'b0;
        resp_xn_o    <= 1'b0;
        // single outstanding access: later ones wait for completion,
        // which keeps device and strongly ordered traffic in order;
        // normal traffic may be reordered, strict order is simpler
        req_ready_o  <= (state_nxt == S_IDLE);
        // barrier tags; a new DMB or DSB wins over the idle clear, an ISB while idle flushes at once
        dmb_pend_r   <= data_order_barrier_i | (dmb_pend_r & (state_r != S_IDLE));
        dsb_pend_r   <= data_sync_barrier_i | (dsb_pend_r & (state_nxt != S_IDLE));
        exec_stall_o <= data_sync_barrier_i | (dsb_pend_r & (state_nxt != S_IDLE));
        isb_pend_r   <= (instr_sync_barrier_i | isb_pend_r) & (state_nxt != S_IDLE);
        prefetch_flush_o <= (instr_sync_barrier_i | isb_pend_r)
                            & (state_nxt == S_IDLE);
        case (state_r)
            S_IDLE: begin
                if (take) begin
                    tgt_sel_o                <= sel_onehot;
                    tgt_mem_type_o           <= d_type;
                    tgt_execute_never_attr_o <= d_xn;
                    periph_slot_o            <= d_paddr[19:12];
                    if (fetch_xn) begin
                        // no bus access; core faults only if it executes it
                        resp_valid_o <= 1'b1;
                        resp_xn_o    <= 1'b1;
                        resp_rdata_o <= 32'h00000000;
                    end else if (d_fault) begin
                        resp_valid_o <= 1'b1;
                        resp_err_o   <= 1'b1;
                        resp_rdata_o <= 32'h00000000;
                    end else begin
                        alias_r     <= d_alias;
                        bit_r       <= d_bit;
                        bitval_r    <= req_wdata_i[0];
                        tgt_valid_o <= 1'b1;
                        tgt_addr_o  <= d_paddr;
                        tgt_wdata_o <= req_wdata_i;
                        // alias write starts with the read half
                        tgt_write_o <= req_write_i & ~d_alias;
                        // strongly ordered writes are never posted
                        posted_r     <= req_write_i & ~d_alias & (d_type == `MT_DEVICE);
                        tgt_posted_o <= req_write_i & ~d_alias & (d_type == `MT_DEVICE);
                        if (req_write_i && !d_alias && d_type == `MT_DEVICE) begin
                            resp_valid_o <= 1'b1;
                        end
                    end
                end
            end
            S_RMW_RD: begin
                if (tgt_done_i) begin
                    tgt_write_o <= 1'b1;
                    tgt_wdata_o <= tgt_rdata_i & ~(32'h00000001 << bit_r)
                                   | ({31'h00000000, bitval_r} << bit_r);
                end
            end
            S_ACCESS: begin
                if (tgt_done_i) begin
                    tgt_valid_o  <= 1'b0;
                    tgt_write_o  <= 1'b0;
                    tgt_posted_o <= 1'b0;
                    posted_r     <= 1'b0;
                    resp_valid_o <= ~posted_r;
                    if (alias_r) begin
                        // alias read shows the bit as 0 or 1
                        resp_rdata_o <= {31'h00000000, tgt_rdata_i[bit_r]};
                    end else begin
                        resp_rdata_o <= tgt_rdata_i;
                    end
                end
            end
            default: begin
                tgt_valid_o <= 1'b0;
            end
        endcase
    end
end

endmodule // system_address_map_decoder

`default_nettype wire

// ===== bench/addr_map_checker.sv
// port-level assertions for the system address map decoder
`timescale 1ns/1ps
`default_nettype none

module addr_map_checker (
    // clock, reset, core side, target done
    input wire logic        ref_clk_i,
    input wire logic        nrst_i,
    input wire logic        data_sync_barrier_i,
    input wire logic        instr_sync_barrier_i,
    input wire logic        region_protection_unit_en_i,
    input wire logic        tgt_done_i,
    // decoder outputs
    input wire logic        resp_valid_o,
    input wire logic        resp_err_o,
    input wire logic        resp_xn_o,
    input wire logic [31:0] resp_rdata_o,
    input wire logic        exec_stall_o,
    input wire logic        prefetch_flush_o,
    input wire logic        tgt_valid_o,
    input wire logic [31:0] tgt_addr_o,
    input wire logic [8:0]  tgt_sel_o,
    input wire logic [1:0]  tgt_mem_type_o,
    input wire logic        tgt_execute_never_attr_o,
    input wire logic        tgt_posted_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    // default attributes only hold while no override is applied
    wire dflt = tgt_valid_o && !region_protection_unit_en_i;

    AST_ONE_SEL: assert property ($onehot(tgt_sel_o)) else $error("select not one-hot");
    AST_FAULT: assert property (resp_valid_o && resp_err_o |->
        tgt_sel_o == 9'h001 && resp_rdata_o == 32'h0) else $error("fault response wrong");
    AST_XN: assert property (resp_valid_o && resp_xn_o |->
        !resp_err_o && resp_rdata_o == 32'h0 && !tgt_valid_o) else $error("xn fetch accessed");
    AST_HOLD: assert property (tgt_valid_o && !tgt_done_i |=>
        tgt_valid_o && $stable(tgt_addr_o)) else $error("access dropped early");
    AST_PERIPH: assert property (dflt && tgt_sel_o[3] |->
        tgt_mem_type_o == 2'h1 && tgt_execute_never_attr_o) else $error("periph attrs");
    AST_PRIV: assert property (dflt && |tgt_sel_o[8:4] |->
        tgt_mem_type_o == 2'h2 && tgt_execute_never_attr_o) else $error("private attrs");
    AST_MEM: assert property (dflt && |tgt_sel_o[2:1] |->
        tgt_mem_type_o == 2'h0 && !tgt_execute_never_attr_o) else $error("memory attrs");
    AST_STRONG: assert property (tgt_valid_o && tgt_mem_type_o == 2'h2 |->
        !tgt_posted_o) else $error("strongly ordered write posted");
    AST_DONE_RESP: assert property (resp_valid_o && !resp_err_o && !resp_xn_o &&
        !tgt_posted_o |-> $past(tgt_done_i)) else $error("answer before completion");
    AST_DSB: assert property (exec_stall_o && !tgt_valid_o && !data_sync_barrier_i |=>
        !exec_stall_o) else $error("stall outlived accesses");
    AST_ISB: assert property (instr_sync_barrier_i && !tgt_valid_o |=>
        prefetch_flush_o ##1 !prefetch_flush_o) else $error("flush pulse wrong");
endmodule // addr_map_checker

bind system_address_map_decoder addr_map_checker addr_map_checker_i (
    .ref_clk_i, .nrst_i, .data_sync_barrier_i, .instr_sync_barrier_i,
    .region_protection_unit_en_i, .tgt_done_i, .resp_valid_o, .resp_err_o, .resp_xn_o,
    .resp_rdata_o, .exec_stall_o, .prefetch_flush_o, .tgt_valid_o, .tgt_addr_o, .tgt_sel_o,
    .tgt_mem_type_o, .tgt_execute_never_attr_o, .tgt_posted_o);

`default_nettype wire

// ===== bench/target_model.sv
// downstream target model answering held decoder accesses
`timescale 1ns/1ps
`default_nettype none

module target_model (
    // clock, reset, answer delay
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic [3:0]  lat_i,
    // downstream access
    input wire logic        valid_i,
    input wire logic        write_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    output logic            done_o,
    output logic [31:0]     rdata_o
);
    logic [31:0] mem [logic [31:0]];
    logic [31:0] lg [$];
    logic [3:0]  wait_r;

    // read data toggles outside the answer cycle so stale values never match
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_o <= 1'b0;
            wait_r <= 4'h0;
            rdata_o <= 32'h0;
        end else begin
            done_o <= 1'b0;
            rdata_o <= ~rdata_o;
            if (valid_i && !done_o) begin
                wait_r <= wait_r + 4'h1;
                if (wait_r >= lat_i) begin
                    done_o <= 1'b1;
                    wait_r <= 4'h0;
                    lg.push_back(addr_i);
                    if (write_i) mem[addr_i] = wdata_i;
                    else rdata_o <= mem.exists(addr_i) ? mem[addr_i] : ~addr_i;
                end
            end
        end
    end
endmodule // target_model

`default_nettype wire

// ===== bench/tb_system_address_map_decoder.sv
// testbench for the system address map decoder
`timescale 1ns/1ps
`default_nettype none

module tb_system_address_map_decoder;
    logic ref_clk_i = 1'b0, nrst_i = 1'b0, req_valid_i = 1'b0, req_write_i = 1'b0;
    logic req_fetch_i = 1'b0, data_order_barrier_i = 1'b0, data_sync_barrier_i = 1'b0;
    logic instr_sync_barrier_i = 1'b0, region_protection_unit_en_i = 1'b0;
    logic region_protection_unit_xn_i = 1'b0, tgt_done_i;
    logic [1:0]  region_protection_unit_type_i = 2'h0;
    logic [31:0] req_addr_i = 32'h0, req_wdata_i = 32'h0, tgt_rdata_i, r_rd;
    logic [3:0]  lat = 4'h1;
    logic        ce = 1'b1;
    logic [8:0]  r_sel;
    logic [7:0]  r_slot;
    logic [1:0]  r_type;
    logic        r_xna, r_err, r_xn, r_post, r_tv;
    wire req_ready_o, resp_valid_o, resp_err_o, resp_xn_o, exec_stall_o, prefetch_flush_o;
    wire tgt_valid_o, tgt_write_o, tgt_execute_never_attr_o, tgt_posted_o;
    wire [31:0] resp_rdata_o, tgt_addr_o, tgt_wdata_o;
    wire [8:0]  tgt_sel_o;
    wire [1:0]  tgt_mem_type_o;
    wire [7:0]  periph_slot_o;
    int fail_count = 0;
    int comparisons = 0;
    logic [31:0] map_a [18] = '{32'h0, 32'h7ffc, 32'h8000, 32'h20001ffc, 32'h20002000,
        32'h22040000, 32'h40000000, 32'h40001000, 32'h400fe000, 32'h44000000, 32'h60000000,
        32'ha0000000, 32'he0000000, 32'he0001000, 32'he0002ffc, 32'he000e000, 32'he0040ffc,
        32'he0041000};
    logic [8:0] map_s [18] = '{9'h002, 9'h002, 9'h001, 9'h004, 9'h001, 9'h001, 9'h008,
        9'h001, 9'h008, 9'h001, 9'h001, 9'h001, 9'h010, 9'h020, 9'h040, 9'h080, 9'h100, 9'h001};

    system_address_map_decoder system_address_map_decoder_i (.ref_clk_i, .nrst_i, .ce_i(ce),
        .req_valid_i, .req_addr_i, .req_write_i, .req_fetch_i, .req_wdata_i, .req_ready_o,
        .resp_valid_o, .resp_err_o, .resp_xn_o, .resp_rdata_o, .data_order_barrier_i,
        .data_sync_barrier_i, .instr_sync_barrier_i, .exec_stall_o, .prefetch_flush_o,
        .region_protection_unit_en_i, .region_protection_unit_type_i,
        .region_protection_unit_xn_i, .tgt_valid_o, .tgt_write_o, .tgt_addr_o, .tgt_wdata_o,
        .tgt_sel_o, .tgt_mem_type_o, .tgt_execute_never_attr_o, .tgt_posted_o, .periph_slot_o,
        .tgt_done_i, .tgt_rdata_i);
    target_model target_model_i (.clk_i(ref_clk_i), .nrst_i, .lat_i(lat), .valid_i(tgt_valid_o),
        .write_i(tgt_write_o), .addr_i(tgt_addr_o), .wdata_i(tgt_wdata_o), .done_o(tgt_done_i),
        .rdata_o(tgt_rdata_i));

    initial begin
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one core request, held until taken, then waits for the answer
    task automatic acc(input logic [31:0] a, input logic w, input logic f, input logic [31:0] d);
        int n;
        n = 0;
        @(negedge ref_clk_i);
        {req_addr_i, req_write_i, req_fetch_i, req_wdata_i, req_valid_i} = {a, w, f, d, 1'b1};
        while (req_ready_o !== 1'b1 && n < 60) begin
            @(negedge ref_clk_i);
            n++;
        end
        @(negedge ref_clk_i);
        req_valid_i = 1'b0;
        {r_sel, r_type, r_xna, r_slot} = {tgt_sel_o, tgt_mem_type_o, tgt_execute_never_attr_o,
            periph_slot_o};
        while (resp_valid_o !== 1'b1 && n < 60) begin
            @(negedge ref_clk_i);
            n++;
        end
        {r_err, r_xn, r_rd, r_post, r_tv} = {resp_err_o, resp_xn_o, resp_rdata_o, tgt_posted_o,
            tgt_valid_o};
        chk("answer in time", 1, n < 60);
    endtask

    task automatic final_report();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_map();
        for (int i = 0; i < 18; i++) begin
            acc(map_a[i], 1'b0, 1'b0, 32'h0);
            chk("select", map_s[i], r_sel);
            chk("fault", map_s[i] == 9'h001, r_err);
        end
        acc(32'h400fd004, 1'b0, 1'b0, 32'h0);
        chk("slot", 8'hfd, r_slot);
    endtask

    task automatic t_xn();
        int n0;
        n0 = target_model_i.lg.size();
        acc(32'h40000000, 1'b0, 1'b1, 32'h0);
        chk("xn fetch", 2'h2, {r_xn, r_err});
        chk("no access", n0, target_model_i.lg.size());
        acc(32'h20000000, 1'b0, 1'b1, 32'h0);
        chk("sram fetch", 0, {r_xn, r_err});
        acc(32'h22000000, 1'b0, 1'b1, 32'h0);
        chk("alias fetch", 2'h1, {r_xn, r_err});
    endtask

    // clock enable low in mid-access: the held access must survive the freeze
    task automatic t_freeze();
        fork
            acc(32'h00000010, 1'b0, 1'b0, 32'h0);
            begin
                repeat (2) @(negedge ref_clk_i);
                ce = 1'b0;
                repeat (4) @(negedge ref_clk_i);
                chk("frozen access", 2'h2, {tgt_valid_o, resp_valid_o});
                ce = 1'b1;
            end
        join
        chk("read after freeze", 32'hffffffef, r_rd);
    endtask

    task automatic t_alias();
        acc(32'h20000000, 1'b1, 1'b0, 32'h1);
        acc(32'h2200001c, 1'b1, 1'b0, 32'h3);
        acc(32'h22000000, 1'b1, 1'b0, 32'hfffffffe);
        acc(32'h20000000, 1'b0, 1'b0, 32'h0);
        chk("bit word", 32'h80, r_rd);
        acc(32'h2200001c, 1'b0, 1'b0, 32'h0);
        chk("alias read", 32'h1, r_rd);
        acc(32'h40004000, 1'b1, 1'b0, 32'h0);
        acc(32'h42080008, 1'b1, 1'b0, 32'h1);
        acc(32'h40004000, 1'b0, 1'b0, 32'h0);
        chk("periph bit", 32'h4, r_rd);
    endtask

    task automatic t_order();
        lat = 4'h6;
        acc(32'h40005000, 1'b1, 1'b0, 32'h55);
        chk("device posted", 2'h3, {r_post, r_tv});
        acc(32'he000e000, 1'b1, 1'b0, 32'h66);
        chk("strong unbuffered", 2'h0, {r_post, r_tv});
        acc(32'h40005000, 1'b0, 1'b0, 32'h0);
        chk("device data", 32'h55, r_rd);
        chk("order", 32'he000e000, target_model_i.lg[$-1]);
        chk("order", 32'h40005000, target_model_i.lg[$-2]);
        lat = 4'h1;
    endtask

    task automatic t_override();
        {region_protection_unit_en_i, region_protection_unit_type_i} = 3'h6;
        region_protection_unit_xn_i = 1'b1;
        acc(32'h0, 1'b0, 1'b0, 32'h0);
        chk("override", 3'h5, {r_type, r_xna});
        {region_protection_unit_en_i, region_protection_unit_xn_i} = 2'h0;
    endtask

    task automatic t_barriers();
        lat = 4'h8;
        @(negedge ref_clk_i) data_sync_barrier_i = 1'b1;
        @(negedge ref_clk_i) data_sync_barrier_i = 1'b0;
        chk("idle stall", 1, exec_stall_o);
        @(negedge ref_clk_i) chk("idle stall end", 0, exec_stall_o);
        fork
            acc(32'h20000000, 1'b0, 1'b0, 32'h0);
            begin
                repeat (3) @(negedge ref_clk_i);
                {data_order_barrier_i, data_sync_barrier_i, instr_sync_barrier_i} = 3'h7;
                @(negedge ref_clk_i) {data_order_barrier_i, data_sync_barrier_i} = 2'h0;
                instr_sync_barrier_i = 1'b0;
                chk("busy stall", 1, exec_stall_o);
                chk("flush waits", 0, prefetch_flush_o);
            end
        join
        acc(32'h20000004, 1'b0, 1'b0, 32'h0);
        chk("after barrier", 32'h20000004, target_model_i.lg[$]);
        @(negedge ref_clk_i) instr_sync_barrier_i = 1'b1;
        @(negedge ref_clk_i) instr_sync_barrier_i = 1'b0;
        chk("flush", 1, prefetch_flush_o);
        lat = 4'h1;
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(negedge ref_clk_i);
        chk("reset select", 9'h001, tgt_sel_o);
        nrst_i = 1'b1;
        t_map();
        t_freeze();
        t_xn();
        t_alias();
        t_order();
        t_override();
        t_barriers();
        final_report();
    end

    initial begin
        #2000000;
        fail_count++;
        final_report();
    end
endmodule // tb_system_address_map_decoder

`default_nettype wire
